// *** pafo_cfg.svh ***
`ifndef PAFO_CFG_SVH
`define PAFO_CFG_SVH

// ----------------------------------------------------------------------
// Port B pin positions
// ----------------------------------------------------------------------
`define PAFO_PB_SEL 0
`define PAFO_PB_SCK 1
`define PAFO_PB_MOSI 2
`define PAFO_PB_MISO 3
`define PAFO_PB_CM0 4
`define PAFO_PB_CM1A 5
`define PAFO_PB_CM1B 6
`define PAFO_PB_CM2 7

// ----------------------------------------------------------------------
// Port D pin positions
// ----------------------------------------------------------------------
`define PAFO_PD_RXD 2
`define PAFO_PD_TXD 3
`define PAFO_PD_CAP 4
`define PAFO_PD_XCK 5
`define PAFO_PD_TC1 6
`define PAFO_PD_TC2 7

// ----------------------------------------------------------------------
// Address-mask thresholds, one per port C bit, bit 7 first
// ----------------------------------------------------------------------
`define PAFO_PC_THR_7 3'h1
`define PAFO_PC_THR_6 3'h2
`define PAFO_PC_THR_5 3'h3
`define PAFO_PC_THR_4 3'h4
`define PAFO_PC_THR_3 3'h5
`define PAFO_PC_THR_2 3'h6
`define PAFO_PC_THR_1 3'h7
`define PAFO_PC_THR_0 3'h7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PAFO_BYTE_RST 8'h00
`define PAFO_PC_OE_RST 8'hFF
`define PAFO_MASK_RST 3'h0

`endif

// *** pafo_pkg.sv ***
package pafo_pkg;
	typedef logic [7:0] pafo_byte_t;
	typedef logic [2:0] pafo_mask_t;
endpackage : pafo_pkg

// *** pafo_pin_mux.sv ***
module pafo_pin_mux #(
	parameter int WIDTH = 8
) (
	// Port register settings and pad level
	input wire logic [WIDTH-1:0] port_reg_i,
	input wire logic [WIDTH-1:0] dir_reg_i,
	input wire logic [WIDTH-1:0] pin_in_i,
	input wire logic global_pullup_disable_i,
	// Override controls
	input wire logic [WIDTH-1:0] pullup_override_enable_i,
	input wire logic [WIDTH-1:0] pullup_override_value_i,
	input wire logic [WIDTH-1:0] direction_override_enable_i,
	input wire logic [WIDTH-1:0] direction_override_value_i,
	input wire logic [WIDTH-1:0] port_value_override_enable_i,
	input wire logic [WIDTH-1:0] port_value_override_value_i,
	input wire logic [WIDTH-1:0] input_enable_override_enable_i,
	input wire logic [WIDTH-1:0] input_enable_override_value_i,
	// Resolved pad controls
	output logic [WIDTH-1:0] pin_out_o,
	output logic [WIDTH-1:0] pin_oe_o,
	output logic [WIDTH-1:0] pullup_o,
	output logic [WIDTH-1:0] pin_data_o
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic in_en;
			// Unless overridden, the pull-up only acts where the direction register marks an input.
			assign pullup_o[i] = pullup_override_enable_i[i] ?
				pullup_override_value_i[i] :
				(port_reg_i[i] & ~dir_reg_i[i] & ~global_pullup_disable_i); // see RQ1
			assign pin_oe_o[i] = direction_override_enable_i[i] ?
				direction_override_value_i[i] : dir_reg_i[i]; // see RQ1
			assign pin_out_o[i] = port_value_override_enable_i[i] ?
				port_value_override_value_i[i] : port_reg_i[i]; // see RQ1
			assign in_en = input_enable_override_enable_i[i] ?
				input_enable_override_value_i[i] : 1'b1; // see RQ1
			assign pin_data_o[i] = pin_in_i[i] & in_en;
		end
	endgenerate
endmodule : pafo_pin_mux

// *** pafo_top.sv ***
`include "pafo_cfg.svh"

// Behaviour
// RQ1 - Override enable selects override value over register
// RQ2 - Slave mode forces clock pin to input
// RQ3 - Forced SPI input keeps register-controlled pull-up
// RQ4 - Slave mode forces select pin to input
// RQ5 - Slave active only while select pin low
// RQ6 - Data pins route master/slave paths correctly
// RQ7 - Compare outputs replace port B upper values
// RQ8 - Legacy mode drops timer1 C compare
// RQ9 - Legacy mode makes port C output-only
// RQ10 - Port C drives outputs from reset
// RQ11 - Port C carries address high byte
// RQ12 - Per-pin mask thresholds release address pins
// RQ13 - Address pin: no pull-up, output, address
// RQ14 - Legacy mode reads mask field as zero
// RQ15 - Port D 7/6 feed timer clocks
// RQ16 - Sync clock direction follows bit4 direction
// RQ17 - Port D bit 4 feeds capture
// RQ18 - Port D 3/2 feed external interrupts
// RQ19 - Transmitter forces port D bit 3 output
// RQ20 - Receiver forces port D bit 2 input
// RQ21 - Legacy mode disables USART1 port functions
// RQ22 - Master mode forces MISO pin input
// RQ23 - Slave mode forces MOSI pin input
module pafo_top (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Port registers and pads
	input wire pafo_pkg::pafo_byte_t portb_output_reg_i,
	input wire pafo_pkg::pafo_byte_t portb_direction_i,
	input wire pafo_pkg::pafo_byte_t portb_pin_i,
	input wire pafo_pkg::pafo_byte_t portc_output_reg_i,
	input wire pafo_pkg::pafo_byte_t portc_direction_i,
	input wire pafo_pkg::pafo_byte_t portc_pin_i,
	input wire pafo_pkg::pafo_byte_t portd_output_reg_i,
	input wire pafo_pkg::pafo_byte_t portd_direction_i,
	input wire pafo_pkg::pafo_byte_t portd_pin_i,
	// Global controls
	input wire logic global_pullup_disable_i,
	input wire logic legacy_mode_i,
	// SPI unit
	input wire logic spi_unit_enable_i,
	input wire logic spi_master_select_i,
	input wire logic spi_master_out_i,
	input wire logic spi_slave_out_i,
	input wire logic spi_clock_out_i,
	// Timer compare outputs
	input wire logic timer0_compare_out_i,
	input wire logic timer0_compare_enable_i,
	input wire logic timer1a_compare_out_i,
	input wire logic timer1a_compare_enable_i,
	input wire logic timer1b_compare_out_i,
	input wire logic timer1b_compare_enable_i,
	input wire logic timer1c_compare_out_i,
	input wire logic timer1c_compare_enable_i,
	input wire logic timer2_compare_out_i,
	input wire logic timer2_compare_enable_i,
	// External memory
	input wire logic ext_memory_enable_i,
	input wire pafo_pkg::pafo_mask_t ext_address_mask_field_i,
	input wire pafo_pkg::pafo_byte_t ext_address_high_i,
	// USART1 and interrupts
	input wire logic usart1_tx_enable_i,
	input wire logic usart1_rx_enable_i,
	input wire logic usart1_transmit_out_i,
	input wire logic usart1_sync_mode_i,
	input wire logic usart1_sync_clock_out_i,
	input wire logic ext_interrupt3_enable_i,
	input wire logic ext_interrupt2_enable_i,
	// Pad controls
	output pafo_pkg::pafo_byte_t portb_pin_out_o,
	output pafo_pkg::pafo_byte_t portb_pin_oe_o,
	output pafo_pkg::pafo_byte_t portb_pullup_o,
	output pafo_pkg::pafo_byte_t portc_pin_out_o,
	output pafo_pkg::pafo_byte_t portc_pin_oe_o,
	output pafo_pkg::pafo_byte_t portc_pullup_o,
	output pafo_pkg::pafo_byte_t portd_pin_out_o,
	output pafo_pkg::pafo_byte_t portd_pin_oe_o,
	output pafo_pkg::pafo_byte_t portd_pullup_o,
	// Peripheral inputs
	output logic spi_master_in_o,
	output logic spi_slave_in_o,
	output logic spi_clock_in_o,
	output logic spi_slave_active_o,
	output logic timer2_ext_clock_in_o,
	output logic timer1_ext_clock_in_o,
	output logic timer1_capture_in_o,
	output logic ext_interrupt3_in_o,
	output logic ext_interrupt2_in_o,
	output logic usart1_receive_in_o,
	output logic usart1_sync_clock_in_o,
	output pafo_pkg::pafo_mask_t ext_address_mask_read_o
);
	import pafo_pkg::*;

	// ------------------------------------------------------------------
	// Override computation
	// ------------------------------------------------------------------
	localparam logic [23:0] PC_THR = {`PAFO_PC_THR_7, `PAFO_PC_THR_6,
		`PAFO_PC_THR_5, `PAFO_PC_THR_4, `PAFO_PC_THR_3, `PAFO_PC_THR_2,
		`PAFO_PC_THR_1, `PAFO_PC_THR_0};

	pafo_byte_t b_puen, b_puvl, b_dren, b_drvl, b_pven, b_pvvl;
	pafo_byte_t c_puen, c_puvl, c_dren, c_drvl, c_pven, c_pvvl;
	pafo_byte_t d_puen, d_puvl, d_dren, d_drvl, d_pven, d_pvvl;
	pafo_byte_t d_inen, d_invl;
	pafo_mask_t mask;
	logic spi_mst, spi_slv, usart_ok, oc7_en, oc7_val;

	always_comb begin
		spi_mst = spi_unit_enable_i & spi_master_select_i;
		spi_slv = spi_unit_enable_i & ~spi_master_select_i;
		// Legacy parts have no extra peripheral pin functions.
		usart_ok = ~legacy_mode_i; // see RQ21
		mask = legacy_mode_i ? `PAFO_MASK_RST : ext_address_mask_field_i; // see RQ14

		// Port B: SPI pins. Forced inputs keep register pull-up.
		b_puen = `PAFO_BYTE_RST;
		b_dren = `PAFO_BYTE_RST;
		b_drvl = `PAFO_BYTE_RST;
		b_pven = `PAFO_BYTE_RST;
		b_pvvl = `PAFO_BYTE_RST;
		b_puvl = portb_output_reg_i & {8{~global_pullup_disable_i}}; // see RQ3
		b_puen[`PAFO_PB_MISO] = spi_mst; // see RQ22
		b_dren[`PAFO_PB_MISO] = spi_mst; // see RQ22
		b_puen[`PAFO_PB_MOSI] = spi_slv; // see RQ23
		b_dren[`PAFO_PB_MOSI] = spi_slv; // see RQ23
		b_puen[`PAFO_PB_SCK] = spi_slv; // see RQ2
		b_dren[`PAFO_PB_SCK] = spi_slv; // see RQ2
		b_puen[`PAFO_PB_SEL] = spi_slv; // see RQ4
		b_dren[`PAFO_PB_SEL] = spi_slv; // see RQ4
		b_pven[`PAFO_PB_MISO] = spi_slv; // see RQ6
		b_pvvl[`PAFO_PB_MISO] = spi_slave_out_i; // see RQ6
		b_pven[`PAFO_PB_MOSI] = spi_mst; // see RQ6
		b_pvvl[`PAFO_PB_MOSI] = spi_master_out_i; // see RQ6
		b_pven[`PAFO_PB_SCK] = spi_mst;
		b_pvvl[`PAFO_PB_SCK] = spi_clock_out_i;

		// Port B: compare outputs, value only.
		b_pven[`PAFO_PB_CM0] = timer0_compare_enable_i; // see RQ7
		b_pvvl[`PAFO_PB_CM0] = timer0_compare_out_i; // see RQ7
		b_pven[`PAFO_PB_CM1A] = timer1a_compare_enable_i; // see RQ7
		b_pvvl[`PAFO_PB_CM1A] = timer1a_compare_out_i; // see RQ7
		b_pven[`PAFO_PB_CM1B] = timer1b_compare_enable_i; // see RQ7
		b_pvvl[`PAFO_PB_CM1B] = timer1b_compare_out_i; // see RQ7
		// With both compares on bit 7 they are modulated: the port bit
		// picks OR when set and AND when clear.
		oc7_en = timer2_compare_enable_i |
			(timer1c_compare_enable_i & ~legacy_mode_i); // see RQ8
		if (timer2_compare_enable_i && timer1c_compare_enable_i &&
			!legacy_mode_i) begin
			oc7_val = portb_output_reg_i[`PAFO_PB_CM2] ?
				(timer2_compare_out_i | timer1c_compare_out_i) :
				(timer2_compare_out_i & timer1c_compare_out_i);
		end else if (timer2_compare_enable_i) begin
			oc7_val = timer2_compare_out_i; // see RQ8
		end else begin
			oc7_val = timer1c_compare_out_i;
		end
		b_pven[`PAFO_PB_CM2] = oc7_en; // see RQ7
		b_pvvl[`PAFO_PB_CM2] = oc7_val; // see RQ7

		// Port C: address high byte, or output-only in legacy mode.
		for (int i = 0; i < 8; i++) begin
			c_pven[i] = ext_memory_enable_i &
				(mask < PC_THR[i*3 +: 3]); // see RQ12
			c_puen[i] = c_pven[i] | legacy_mode_i; // see RQ13
			c_dren[i] = c_pven[i] | legacy_mode_i; // see RQ9
		end
		c_puvl = `PAFO_BYTE_RST; // see RQ13
		c_drvl = ~`PAFO_BYTE_RST; // see RQ13
		c_pvvl = ext_address_high_i; // see RQ11

		// Port D: USART1 pins and interrupt input enables.
		d_puen = `PAFO_BYTE_RST;
		d_puvl = `PAFO_BYTE_RST;
		d_dren = `PAFO_BYTE_RST;
		d_drvl = `PAFO_BYTE_RST;
		d_pven = `PAFO_BYTE_RST;
		d_pvvl = `PAFO_BYTE_RST;
		d_inen = `PAFO_BYTE_RST;
		d_invl = ~`PAFO_BYTE_RST;
		d_puen[`PAFO_PD_TXD] = usart1_tx_enable_i & usart_ok; // see RQ19
		d_dren[`PAFO_PD_TXD] = usart1_tx_enable_i & usart_ok; // see RQ19
		d_drvl[`PAFO_PD_TXD] = 1'b1; // see RQ19
		d_pven[`PAFO_PD_TXD] = usart1_tx_enable_i & usart_ok; // see RQ19
		d_pvvl[`PAFO_PD_TXD] = usart1_transmit_out_i; // see RQ19
		d_puen[`PAFO_PD_RXD] = usart1_rx_enable_i & usart_ok; // see RQ20
		d_puvl[`PAFO_PD_RXD] = portd_output_reg_i[`PAFO_PD_RXD] &
			~global_pullup_disable_i; // see RQ20
		d_dren[`PAFO_PD_RXD] = usart1_rx_enable_i & usart_ok; // see RQ20
		d_dren[`PAFO_PD_XCK] = usart1_sync_mode_i & usart_ok; // see RQ16
		d_drvl[`PAFO_PD_XCK] = portd_direction_i[`PAFO_PD_CAP]; // see RQ16
		d_pven[`PAFO_PD_XCK] = usart1_sync_mode_i & usart_ok; // see RQ16
		d_pvvl[`PAFO_PD_XCK] = usart1_sync_clock_out_i; // see RQ16
		d_inen[`PAFO_PD_TXD] = ext_interrupt3_enable_i; // see RQ18
		d_inen[`PAFO_PD_RXD] = ext_interrupt2_enable_i; // see RQ18
	end

	// ------------------------------------------------------------------
	// Pin resolution
	// ------------------------------------------------------------------
	pafo_byte_t b_out, b_oe, b_pu, b_data;
	pafo_byte_t c_out, c_oe, c_pu, c_data;
	pafo_byte_t d_out, d_oe, d_pu, d_data;

	pafo_pin_mux #(.WIDTH(8)) u_portb (
		.port_reg_i(portb_output_reg_i),
		.dir_reg_i(portb_direction_i),
		.pin_in_i(portb_pin_i),
		.global_pullup_disable_i(global_pullup_disable_i),
		.pullup_override_enable_i(b_puen),
		.pullup_override_value_i(b_puvl),
		.direction_override_enable_i(b_dren),
		.direction_override_value_i(b_drvl),
		.port_value_override_enable_i(b_pven),
		.port_value_override_value_i(b_pvvl),
		.input_enable_override_enable_i(`PAFO_BYTE_RST),
		.input_enable_override_value_i(`PAFO_BYTE_RST),
		.pin_out_o(b_out),
		.pin_oe_o(b_oe),
		.pullup_o(b_pu),
		.pin_data_o(b_data)
	);

	pafo_pin_mux #(.WIDTH(8)) u_portc (
		.port_reg_i(portc_output_reg_i),
		.dir_reg_i(portc_direction_i),
		.pin_in_i(portc_pin_i),
		.global_pullup_disable_i(global_pullup_disable_i),
		.pullup_override_enable_i(c_puen),
		.pullup_override_value_i(c_puvl),
		.direction_override_enable_i(c_dren),
		.direction_override_value_i(c_drvl),
		.port_value_override_enable_i(c_pven),
		.port_value_override_value_i(c_pvvl),
		.input_enable_override_enable_i(`PAFO_BYTE_RST),
		.input_enable_override_value_i(`PAFO_BYTE_RST),
		.pin_out_o(c_out),
		.pin_oe_o(c_oe),
		.pullup_o(c_pu),
		.pin_data_o(c_data)
	);

	pafo_pin_mux #(.WIDTH(8)) u_portd (
		.port_reg_i(portd_output_reg_i),
		.dir_reg_i(portd_direction_i),
		.pin_in_i(portd_pin_i),
		.global_pullup_disable_i(global_pullup_disable_i),
		.pullup_override_enable_i(d_puen),
		.pullup_override_value_i(d_puvl),
		.direction_override_enable_i(d_dren),
		.direction_override_value_i(d_drvl),
		.port_value_override_enable_i(d_pven),
		.port_value_override_value_i(d_pvvl),
		.input_enable_override_enable_i(d_inen),
		.input_enable_override_value_i(d_invl),
		.pin_out_o(d_out),
		.pin_oe_o(d_oe),
		.pullup_o(d_pu),
		.pin_data_o(d_data)
	);

	// ------------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------------
	// Everything is registered, so pad and peripheral paths see one
	// cycle of latency; the peripherals must tolerate that skew.
	logic [10:0] next_periph, periph;
	pafo_byte_t pad [9];
	pafo_byte_t next_pad [9];
	pafo_mask_t next_mask_read;

	always_comb begin
		next_pad[0] = b_out;
		next_pad[1] = b_oe;
		next_pad[2] = b_pu;
		next_pad[3] = c_out;
		next_pad[4] = c_oe;
		next_pad[5] = c_pu;
		next_pad[6] = d_out;
		next_pad[7] = d_oe;
		next_pad[8] = d_pu;
		next_mask_read = mask; // see RQ14
		next_periph = '0;
		next_periph[0] = b_data[`PAFO_PB_MISO]; // see RQ6
		next_periph[1] = b_data[`PAFO_PB_MOSI]; // see RQ6
		next_periph[2] = b_data[`PAFO_PB_SCK];
		next_periph[3] = spi_slv & ~b_data[`PAFO_PB_SEL]; // see RQ5
		next_periph[4] = d_data[`PAFO_PD_TC2]; // see RQ15
		next_periph[5] = d_data[`PAFO_PD_TC1]; // see RQ15
		next_periph[6] = d_data[`PAFO_PD_CAP]; // see RQ17
		next_periph[7] = d_data[`PAFO_PD_TXD]; // see RQ18
		next_periph[8] = d_data[`PAFO_PD_RXD]; // see RQ18
		next_periph[9] = d_data[`PAFO_PD_RXD] & usart_ok; // see RQ21
		next_periph[10] = d_data[`PAFO_PD_XCK] & usart_ok &
			usart1_sync_mode_i; // see RQ16
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < 9; i++) begin
				pad[i] <= `PAFO_BYTE_RST;
			end
			// Port C drives from reset since legacy mode is the default.
			pad[4] <= `PAFO_PC_OE_RST; // see RQ10
			periph <= '0;
			ext_address_mask_read_o <= `PAFO_MASK_RST;
		end else begin
			pad <= next_pad;
			periph <= next_periph;
			ext_address_mask_read_o <= next_mask_read;
		end
	end

	assign portb_pin_out_o = pad[0];
	assign portb_pin_oe_o = pad[1];
	assign portb_pullup_o = pad[2];
	assign portc_pin_out_o = pad[3];
	assign portc_pin_oe_o = pad[4];
	assign portc_pullup_o = pad[5];
	assign portd_pin_out_o = pad[6];
	assign portd_pin_oe_o = pad[7];
	assign portd_pullup_o = pad[8];
	assign spi_master_in_o = periph[0];
	assign spi_slave_in_o = periph[1];
	assign spi_clock_in_o = periph[2];
	assign spi_slave_active_o = periph[3];
	assign timer2_ext_clock_in_o = periph[4];
	assign timer1_ext_clock_in_o = periph[5];
	assign timer1_capture_in_o = periph[6];
	assign ext_interrupt3_in_o = periph[7];
	assign ext_interrupt2_in_o = periph[8];
	assign usart1_receive_in_o = periph[9];
	assign usart1_sync_clock_in_o = periph[10];
endmodule : pafo_top

// *** pafo_checker.sv ***
module pafo_checker (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Watched inputs
	input wire pafo_pkg::pafo_byte_t portb_output_reg_i,
	input wire pafo_pkg::pafo_byte_t portb_direction_i,
	input wire pafo_pkg::pafo_byte_t portb_pin_i,
	input wire pafo_pkg::pafo_byte_t portd_pin_i,
	input wire logic global_pullup_disable_i,
	input wire logic legacy_mode_i,
	input wire logic spi_unit_enable_i,
	input wire logic spi_master_select_i,
	input wire logic spi_master_out_i,
	input wire logic timer1a_compare_out_i,
	input wire logic timer1a_compare_enable_i,
	input wire logic ext_memory_enable_i,
	input wire pafo_pkg::pafo_mask_t ext_address_mask_field_i,
	input wire pafo_pkg::pafo_byte_t ext_address_high_i,
	input wire logic usart1_tx_enable_i,
	input wire logic usart1_rx_enable_i,
	input wire logic usart1_transmit_out_i,
	input wire logic usart1_sync_mode_i,
	// Watched outputs
	input wire pafo_pkg::pafo_byte_t portb_pin_out_o,
	input wire pafo_pkg::pafo_byte_t portb_pin_oe_o,
	input wire pafo_pkg::pafo_byte_t portb_pullup_o,
	input wire pafo_pkg::pafo_byte_t portc_pin_out_o,
	input wire pafo_pkg::pafo_byte_t portc_pin_oe_o,
	input wire pafo_pkg::pafo_byte_t portc_pullup_o,
	input wire pafo_pkg::pafo_byte_t portd_pin_out_o,
	input wire pafo_pkg::pafo_byte_t portd_pin_oe_o,
	input wire logic spi_master_in_o,
	input wire logic spi_clock_in_o,
	input wire logic spi_slave_active_o,
	input wire logic timer2_ext_clock_in_o,
	input wire logic timer1_ext_clock_in_o,
	input wire logic timer1_capture_in_o,
	input wire logic ext_interrupt3_in_o,
	input wire logic ext_interrupt2_in_o,
	input wire logic usart1_receive_in_o,
	input wire logic usart1_sync_clock_in_o,
	input wire pafo_pkg::pafo_mask_t ext_address_mask_read_o
);
	import pafo_pkg::*;
	// Every output is its inputs one edge later, so each check uses |=>.
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	a_slave_pins_in: assert property (
		spi_unit_enable_i && !spi_master_select_i |=>
		portb_pin_oe_o[2:0] == 3'h0 && portb_pullup_o[2:0] ==
		($past(portb_output_reg_i[2:0]) &
		~{3{$past(global_pullup_disable_i)}}))
		else $error("slave mode SPI pins not forced to input");
	a_master_miso_in: assert property (
		spi_unit_enable_i && spi_master_select_i |=> !portb_pin_oe_o[3] &&
		portb_pin_oe_o[2:0] == $past(portb_direction_i[2:0]) &&
		portb_pin_out_o[2] == $past(spi_master_out_i) &&
		spi_master_in_o == $past(portb_pin_i[3]))
		else $error("master mode SPI pins wrong");
	a_select_low_active: assert property (
		1'b1 |=> spi_slave_active_o == $past(spi_unit_enable_i &&
		!spi_master_select_i && !portb_pin_i[0]))
		else $error("slave activity does not follow select pin");
	a_compare_drives: assert property (
		timer1a_compare_enable_i |=>
		portb_pin_out_o[5] == $past(timer1a_compare_out_i) &&
		portb_pin_oe_o[5] == $past(portb_direction_i[5]))
		else $error("compare output not on its pin");
	a_legacy_portc_out: assert property (
		legacy_mode_i |=> portc_pin_oe_o == 8'hFF &&
		ext_address_mask_read_o == 3'h0 && !usart1_receive_in_o)
		else $error("legacy mode not applied");
	a_address_byte: assert property (
		ext_memory_enable_i && ext_address_mask_field_i == 3'h0 |=>
		portc_pin_out_o == $past(ext_address_high_i) &&
		portc_pin_oe_o == 8'hFF && portc_pullup_o == 8'h00)
		else $error("address high byte not on port C");
	a_tx_forced_out: assert property (
		usart1_tx_enable_i && !legacy_mode_i |=> portd_pin_oe_o[3] &&
		portd_pin_out_o[3] == $past(usart1_transmit_out_i))
		else $error("transmit pin not driven");
	a_rx_forced_in: assert property (
		usart1_rx_enable_i && !legacy_mode_i |=> !portd_pin_oe_o[2] &&
		usart1_receive_in_o == $past(portd_pin_i[2]))
		else $error("receive pin not an input");
	a_timer_pin_route: assert property (
		1'b1 |=> {timer2_ext_clock_in_o, timer1_ext_clock_in_o,
		timer1_capture_in_o, ext_interrupt3_in_o, ext_interrupt2_in_o} ==
		$past({portd_pin_i[7:6], portd_pin_i[4:2]}))
		else $error("port D input routing wrong");
	a_clock_pin_route: assert property (
		1'b1 |=> spi_clock_in_o == $past(portb_pin_i[1]) &&
		usart1_sync_clock_in_o == $past(portd_pin_i[5] &&
		usart1_sync_mode_i && !legacy_mode_i))
		else $error("clock pin inputs not routed");
endmodule : pafo_checker

bind pafo_top pafo_checker u_checker (.clk_i, .sys_rst_i,
	.portb_output_reg_i, .portb_direction_i, .portb_pin_i, .portd_pin_i,
	.global_pullup_disable_i, .legacy_mode_i, .spi_unit_enable_i,
	.spi_master_select_i, .spi_master_out_i, .timer1a_compare_out_i,
	.timer1a_compare_enable_i, .ext_memory_enable_i,
	.ext_address_mask_field_i, .ext_address_high_i, .usart1_tx_enable_i,
	.usart1_rx_enable_i, .usart1_transmit_out_i, .portb_pin_out_o,
	.portb_pin_oe_o, .portb_pullup_o, .portc_pin_out_o, .portc_pin_oe_o,
	.portc_pullup_o, .portd_pin_out_o, .portd_pin_oe_o, .spi_master_in_o,
	.spi_slave_active_o, .timer2_ext_clock_in_o, .timer1_ext_clock_in_o,
	.timer1_capture_in_o, .ext_interrupt3_in_o, .ext_interrupt2_in_o,
	.usart1_receive_in_o, .ext_address_mask_read_o, .usart1_sync_mode_i,
	.spi_clock_in_o, .usart1_sync_clock_in_o);

// *** pafo_board_pad.sv ***
module pafo_board_pad (
	// Clock
	input wire logic clk_i,
	// Pad controls from the block
	input wire pafo_pkg::pafo_byte_t pin_out_i,
	input wire pafo_pkg::pafo_byte_t pin_oe_i,
	input wire pafo_pkg::pafo_byte_t pullup_i,
	// Board drivers, such as an external SPI master
	input wire pafo_pkg::pafo_byte_t ext_en_i,
	input wire pafo_pkg::pafo_byte_t ext_val_i,
	// Resolved pad level
	output pafo_pkg::pafo_byte_t pin_o
);
	import pafo_pkg::*;
	pafo_byte_t churn;
	// A floating pad flips every cycle so a stale level never looks valid.
	always @(posedge clk_i) churn <= (churn === 8'h55) ? 8'hAA : 8'h55;
	assign pin_o = (pin_oe_i & pin_out_i) |
		(~pin_oe_i & ext_en_i & ext_val_i) |
		(~pin_oe_i & ~ext_en_i & (pullup_i | churn));
endmodule : pafo_board_pad

// *** pafo_top_tb.sv ***
module pafo_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pafo_pkg::*;
	localparam int PUDIS = 0, LEG = 1, SPIEN = 2, MST = 3, XMEN = 17;
	localparam int TXE = 18, RXE = 19, SYN = 21;
	logic clk, rst, ssi, sact;
	logic [24:0] ctl;
	pafo_mask_t mask, mrd;
	pafo_byte_t pbr, pbd, pcr, pcd, pdr, pdd, adr, xe, xv, pbp, pcp, pdp;
	pafo_byte_t pbo, pbe, pbu, pco, pce, pcu, pdo, pde, pdu;
	int err_count, tests_run;
	pafo_byte_t ed;

	pafo_top dut (.clk_i(clk), .sys_rst_i(rst),
		.portb_output_reg_i(pbr), .portb_direction_i(pbd), .portb_pin_i(pbp),
		.portc_output_reg_i(pcr), .portc_direction_i(pcd), .portc_pin_i(pcp),
		.portd_output_reg_i(pdr), .portd_direction_i(pdd), .portd_pin_i(pdp),
		.global_pullup_disable_i(ctl[0]), .legacy_mode_i(ctl[1]),
		.spi_unit_enable_i(ctl[2]), .spi_master_select_i(ctl[3]),
		.spi_master_out_i(ctl[4]), .spi_slave_out_i(ctl[5]),
		.spi_clock_out_i(ctl[6]), .timer0_compare_out_i(ctl[7]),
		.timer0_compare_enable_i(ctl[8]), .timer1a_compare_out_i(ctl[9]),
		.timer1a_compare_enable_i(ctl[10]), .timer1b_compare_out_i(ctl[11]),
		.timer1b_compare_enable_i(ctl[12]), .timer1c_compare_out_i(ctl[13]),
		.timer1c_compare_enable_i(ctl[14]), .timer2_compare_out_i(ctl[15]),
		.timer2_compare_enable_i(ctl[16]), .ext_memory_enable_i(ctl[17]),
		.ext_address_mask_field_i(mask), .ext_address_high_i(adr),
		.usart1_tx_enable_i(ctl[18]), .usart1_rx_enable_i(ctl[19]),
		.usart1_transmit_out_i(ctl[20]), .usart1_sync_mode_i(ctl[21]),
		.usart1_sync_clock_out_i(ctl[22]), .ext_interrupt3_enable_i(ctl[23]),
		.ext_interrupt2_enable_i(ctl[24]), .portb_pin_out_o(pbo),
		.portb_pin_oe_o(pbe), .portb_pullup_o(pbu), .portc_pin_out_o(pco),
		.portc_pin_oe_o(pce), .portc_pullup_o(pcu), .portd_pin_out_o(pdo),
		.portd_pin_oe_o(pde), .portd_pullup_o(pdu), .spi_master_in_o(),
		.spi_slave_in_o(ssi), .spi_clock_in_o(), .spi_slave_active_o(sact),
		.timer2_ext_clock_in_o(), .timer1_ext_clock_in_o(),
		.timer1_capture_in_o(), .ext_interrupt3_in_o(), .ext_interrupt2_in_o(),
		.usart1_receive_in_o(), .usart1_sync_clock_in_o(),
		.ext_address_mask_read_o(mrd));
	pafo_board_pad pad_b (.clk_i(clk), .pin_out_i(pbo), .pin_oe_i(pbe),
		.pullup_i(pbu), .ext_en_i(xe), .ext_val_i(xv), .pin_o(pbp));
	pafo_board_pad pad_c (.clk_i(clk), .pin_out_i(pco), .pin_oe_i(pce),
		.pullup_i(pcu), .ext_en_i(xe), .ext_val_i(xv), .pin_o(pcp));
	pafo_board_pad pad_d (.clk_i(clk), .pin_out_i(pdo), .pin_oe_i(pde),
		.pullup_i(pdu), .ext_en_i(xe), .ext_val_i(xv), .pin_o(pdp));

	// ------------------------------------------------------------------
	// Expected values
	// ------------------------------------------------------------------
	function automatic logic taken(input int i);
		pafo_mask_t m;
		m = ctl[LEG] ? 3'h0 : mask;
		return ctl[XMEN] && (m < ((i == 0) ? 7 : 8 - i));
	endfunction : taken

	function automatic pafo_byte_t exp_oe(input int p);
		pafo_byte_t e;
		e = (p == 0) ? pbd : (p == 1) ? pcd : pdd;
		if (p == 0 && ctl[SPIEN] && ctl[MST]) e[3] = 1'b0;
		if (p == 0 && ctl[SPIEN] && !ctl[MST]) e[2:0] = 3'h0;
		for (int i = 0; i < 8; i++) begin
			if (p == 1 && taken(i)) e[i] = 1'b1;
		end
		if (p == 1 && ctl[LEG]) e = 8'hFF;
		if (p == 2 && !ctl[LEG]) begin
			if (ctl[SYN]) e[5] = pdd[4];
			if (ctl[TXE]) e[3] = 1'b1;
			if (ctl[RXE]) e[2] = 1'b0;
		end
		return e;
	endfunction : exp_oe

	function automatic pafo_byte_t exp_pc_out();
		pafo_byte_t o;
		for (int i = 0; i < 8; i++) begin
			o[i] = taken(i) ? adr[i] : pcr[i];
		end
		return o;
	endfunction : exp_pc_out

	function automatic logic [3:0] exp_pb_hi();
		logic [3:0] o;
		logic c1;
		o = pbr[7:4];
		c1 = ctl[14] && !ctl[LEG];
		if (ctl[8]) o[0] = ctl[7];
		if (ctl[10]) o[1] = ctl[9];
		if (ctl[12]) o[2] = ctl[11];
		if (ctl[16] && c1) o[3] = pbr[7] ? ctl[15] | ctl[13] : ctl[15] & ctl[13];
		else if (ctl[16]) o[3] = ctl[15];
		else if (c1) o[3] = ctl[13];
		return o;
	endfunction : exp_pb_hi

	// ------------------------------------------------------------------
	// Compare and verdict
	// ------------------------------------------------------------------
	task automatic cmp(input string what, input pafo_byte_t exp, got);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : give_verdict

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		give_verdict();
	end

	initial begin
		err_count = 0;
		tests_run = 0;
		rst = 1'b1;
		ctl = 25'h2;
		{mask, pbr, pbd, pcr, pcd, pdr, pdd, adr, xe, xv} = '0;
		void'($urandom(13));
		repeat (12) @(negedge clk);
		cmp("reset portc oe", 8'hFF, pce);
		cmp("reset portb oe", 8'h00, pbe);
		$display("test reset done");
		rst = 1'b0;
		// Early rounds keep the delivered legacy setting.
		for (int n = 0; n < 200; n++) begin
			ctl = 25'($urandom);
			ctl[LEG] = (n < 20) || ($urandom % 4 == 0);
			{mask, pbr, pbd, pcr} = 27'($urandom);
			{pcd, pdr, pdd, adr} = $urandom;
			{xe, xv} = 16'($urandom);
			if (n % 10 == 0) mask = 3'h0;
			@(negedge clk);
			cmp("portb oe", exp_oe(0), pbe);
			cmp("portc oe", exp_oe(1), pce);
			cmp("portd oe", exp_oe(2), pde);
			// The clock pin's pull-up still reads its own direction bit.
			ed = exp_oe(2);
			ed[5] = pdd[5];
			cmp("portb pullup", pbr & ~exp_oe(0) & ~{8{ctl[PUDIS]}}, pbu);
			cmp("portc pullup", pcr & ~exp_oe(1) & ~{8{ctl[PUDIS]}}, pcu);
			cmp("portd pullup", pdr & ~ed & ~{8{ctl[PUDIS]}}, pdu);
			cmp("portc out", exp_pc_out(), pco);
			cmp("portb out hi", {4'h0, exp_pb_hi()}, {4'h0, pbo[7:4]});
			cmp("mask read", {5'h0, ctl[LEG] ? 3'h0 : mask}, {5'h0, mrd});
		end
		$display("test random overrides done");
		ctl = 25'h4;
		xe = 8'h05;
		xv = 8'h04;
		repeat (2) @(negedge clk);
		cmp("slave active", 8'h01, {7'h0, sact});
		cmp("slave in", 8'h01, {7'h0, ssi});
		ctl[5] = 1'b1;
		xv[0] = 1'b1;
		repeat (2) @(negedge clk);
		cmp("slave idle", 8'h00, {7'h0, sact});
		cmp("slave out pin", 8'h01, {7'h0, pbo[3]});
		$display("test slave select done");
		give_verdict();
	end
endmodule : pafo_top_tb
